/* File: atc_pkg.sv */
package atc_pkg;
    // -------------------------------------------------------------------
    // special-function addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL    = 8'hc8; // aux_timer_control
    localparam logic [7:0] ADDR_MODE       = 8'hc9; // aux_timer_mode
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca; // capture_reload_low
    localparam logic [7:0] ADDR_RELOAD_HI  = 8'hcb; // capture_reload_high
    localparam logic [7:0] ADDR_COUNT_LOW  = 8'hcc; // count_low
    localparam logic [7:0] ADDR_COUNT_HI   = 8'hcd; // count_high

    // -------------------------------------------------------------------
    // control register field positions
    // -------------------------------------------------------------------
    localparam int BIT_OVF   = 7; // overflow_flag
    localparam int BIT_EXF   = 6; // external_event_flag
    localparam int BIT_RCLK  = 5; // rx_baud_source_sel
    localparam int BIT_TX_BAUD_SOURCE_SEL  = 4; // tx_baud_source_sel
    localparam int BIT_EXEN  = 3; // ext_trigger_enable
    localparam int BIT_RUN   = 2; // run_control
    localparam int BIT_CSRC  = 1; // count_source_sel
    localparam int BIT_CPRL  = 0; // capture_reload_sel
    localparam int BIT_UPDOWN_COUNT_ENABLE  = 0; // updown_count_enable in mode register

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    localparam logic [15:0] WORD_ALL_ONES = 16'hffff;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;

    // -------------------------------------------------------------------
    // timing: core clocks per machine cycle
    // -------------------------------------------------------------------
    localparam int          MACHINE_CYCLE_CLKS = 12;
    localparam logic [3:0]  PRESCALE_LAST      = 4'(MACHINE_CYCLE_CLKS - 1);
    localparam logic [3:0]  PRESCALE_ZERO      = 4'h0;

    // serial port modes that take their baud clock from a timer
    localparam logic [1:0]  SERIAL_MODE_1 = 2'h1;
    localparam logic [1:0]  SERIAL_MODE_3 = 2'h3;
endpackage : atc_pkg

/* File: atc_pin_sync.sv */
`timescale 1ns/1ns
// three-stage pin synchroniser with a falling-edge pulse
module atc_pin_sync
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic srst_in,
    // pin and result
    input  wire logic pin_in,
    output logic      fall_out
);
    logic s1_reg;    // first stage, read only by s2
    logic s2_reg;    // second stage
    logic s3_reg;    // third stage
    logic level_reg; // accepted pin level

    // -------------------------------------------------------------------
    // synchroniser chain
    // -------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // -------------------------------------------------------------------
    // accept a change once stages two and three agree
    // -------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            level_reg <= 1'b1;
            fall_out  <= 1'b0;
        end
        else
        begin
            if (s2_reg == s3_reg)
                level_reg <= s2_reg;
            // one pulse per accepted high-to-low change
            fall_out <= (s2_reg == s3_reg) && !s2_reg && level_reg;
        end
    end
endmodule : atc_pin_sync

/* File: atc_timer.sv */
`timescale 1ns/1ns
module atc_timer
(
    // clock and reset
    input  wire logic       CORE_CLK_IN,
    input  wire logic       SRST_IN,
    // special-function register access
    input  wire logic [7:0] SFR_ADDR_IN,
    input  wire logic       SFR_WR_IN,
    input  wire logic       SFR_RD_IN,
    input  wire logic [7:0] SFR_WDATA_IN,
    output logic      [7:0] SFR_RDATA_OUT,
    // pins
    input  wire logic       COUNT_PIN_IN,
    input  wire logic       EXT_TRIGGER_PIN_IN,
    // interrupt
    input  wire logic       TIMER_INT_EN_IN,
    output logic            TIMER_IRQ_OUT,
    // serial port
    input  wire logic [1:0] SERIAL_MODE_IN,
    input  wire logic       TIMER1_OVF_IN,
    output logic            RX_BAUD_TICK_OUT,
    output logic            TX_BAUD_TICK_OUT
);
    logic [7:0]  control_reg;  // aux_timer_control
    logic        updown_count_enable_reg;     // updown_count_enable
    logic [15:0] reload_reg;   // capture_reload pair
    logic [15:0] count_reg;    // count pair
    logic [3:0]  prescale_reg; // machine cycle divider
    logic        count_fall;   // synchronised count pin fall
    logic        trig_fall;    // synchronised trigger pin fall
    logic        baud_use;     // timer drives serial clock
    logic        tick;         // one counting step
    logic        overflow;     // roll from all ones
    logic        trig_event;   // accepted trigger edge
    logic        do_capture;
    logic        do_reload;
    logic        wr_ctrl;
    logic        wr_mode;
    logic        wr_rl_lo;
    logic        wr_rl_hi;
    logic        wr_cnt_lo;
    logic        wr_cnt_hi;
    logic        timer_mode;   // serial mode uses timer baud

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    atc_pin_sync u_count_sync
    (
        .clk_in   (CORE_CLK_IN),
        .srst_in  (SRST_IN),
        .pin_in   (COUNT_PIN_IN),
        .fall_out (count_fall)
    );

    atc_pin_sync u_trig_sync
    (
        .clk_in   (CORE_CLK_IN),
        .srst_in  (SRST_IN),
        .pin_in   (EXT_TRIGGER_PIN_IN),
        .fall_out (trig_fall)
    );

    // -------------------------------------------------------------------
    // decode and event logic
    // -------------------------------------------------------------------
    always_comb
    begin
        wr_ctrl   = SFR_WR_IN && (SFR_ADDR_IN == atc_pkg::ADDR_CONTROL);
        wr_mode   = SFR_WR_IN && (SFR_ADDR_IN == atc_pkg::ADDR_MODE);
        wr_rl_lo  = SFR_WR_IN && (SFR_ADDR_IN == atc_pkg::ADDR_RELOAD_LOW);
        wr_rl_hi  = SFR_WR_IN && (SFR_ADDR_IN == atc_pkg::ADDR_RELOAD_HI);
        wr_cnt_lo = SFR_WR_IN && (SFR_ADDR_IN == atc_pkg::ADDR_COUNT_LOW);
        wr_cnt_hi = SFR_WR_IN && (SFR_ADDR_IN == atc_pkg::ADDR_COUNT_HI);
        baud_use  = control_reg[atc_pkg::BIT_RCLK] || control_reg[atc_pkg::BIT_TX_BAUD_SOURCE_SEL];
        // timer: machine cycles; counter: pin falls
        tick      = control_reg[atc_pkg::BIT_RUN]
                    && (control_reg[atc_pkg::BIT_CSRC] ? count_fall
                        : (prescale_reg == atc_pkg::PRESCALE_LAST));
        overflow  = tick && (count_reg == atc_pkg::WORD_ALL_ONES);
        // trigger only with enable set and not in baud use
        trig_event = trig_fall && control_reg[atc_pkg::BIT_EXEN] && !baud_use;
        do_capture = trig_event && control_reg[atc_pkg::BIT_CPRL];
        // reload on overflow unless capture mode; baud use forces it
        do_reload  = (overflow && (!control_reg[atc_pkg::BIT_CPRL] || baud_use))
                     || (trig_event && !control_reg[atc_pkg::BIT_CPRL]);
        timer_mode = (SERIAL_MODE_IN == atc_pkg::SERIAL_MODE_1)
                     || (SERIAL_MODE_IN == atc_pkg::SERIAL_MODE_3);
    end

    // -------------------------------------------------------------------
    // machine cycle prescaler
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (SRST_IN)
            prescale_reg <= atc_pkg::PRESCALE_ZERO;
        else if (prescale_reg == atc_pkg::PRESCALE_LAST)
            prescale_reg <= atc_pkg::PRESCALE_ZERO;
        else
            prescale_reg <= prescale_reg + 4'h1;
    end

    // -------------------------------------------------------------------
    // control register, flags set over software clear
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (SRST_IN)
            control_reg <= atc_pkg::CONTROL_RESET;
        else
        begin
            if (wr_ctrl)
                control_reg <= SFR_WDATA_IN;
            // flag set wins over a same-cycle clear
            if (overflow && !baud_use)
                control_reg[atc_pkg::BIT_OVF] <= 1'b1;
            if (trig_event)
                control_reg[atc_pkg::BIT_EXF] <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // mode register: up/down enable
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (SRST_IN)
            updown_count_enable_reg <= 1'b0;
        else if (wr_mode)
            updown_count_enable_reg <= SFR_WDATA_IN[atc_pkg::BIT_UPDOWN_COUNT_ENABLE];
    end

    // -------------------------------------------------------------------
    // capture/reload pair
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (SRST_IN)
            reload_reg <= atc_pkg::WORD_RESET;
        else if (do_capture)
            reload_reg <= count_reg;
        else
        begin
            if (wr_rl_lo)
                reload_reg[7:0] <= SFR_WDATA_IN;
            if (wr_rl_hi)
                reload_reg[15:8] <= SFR_WDATA_IN;
        end
    end

    // -------------------------------------------------------------------
    // counter: software write wins, then reload, then step
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (SRST_IN)
            count_reg <= atc_pkg::WORD_RESET;
        else if (wr_cnt_lo || wr_cnt_hi)
        begin
            if (wr_cnt_lo)
                count_reg[7:0] <= SFR_WDATA_IN;
            if (wr_cnt_hi)
                count_reg[15:8] <= SFR_WDATA_IN;
        end
        else if (do_reload)
            count_reg <= reload_reg;
        else if (tick)
            count_reg <= count_reg + 16'h0001;
    end

    // -------------------------------------------------------------------
    // registered read data
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (SRST_IN)
            SFR_RDATA_OUT <= atc_pkg::BYTE_ZERO;
        else if (SFR_RD_IN)
        begin
            unique case (SFR_ADDR_IN)
                atc_pkg::ADDR_CONTROL:    SFR_RDATA_OUT <= control_reg;
                atc_pkg::ADDR_MODE:       SFR_RDATA_OUT <= {7'h00, updown_count_enable_reg};
                atc_pkg::ADDR_RELOAD_LOW: SFR_RDATA_OUT <= reload_reg[7:0];
                atc_pkg::ADDR_RELOAD_HI:  SFR_RDATA_OUT <= reload_reg[15:8];
                atc_pkg::ADDR_COUNT_LOW:  SFR_RDATA_OUT <= count_reg[7:0];
                atc_pkg::ADDR_COUNT_HI:   SFR_RDATA_OUT <= count_reg[15:8];
                default:                  SFR_RDATA_OUT <= atc_pkg::BYTE_ZERO;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // interrupt request and baud clock selection
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (SRST_IN)
        begin
            TIMER_IRQ_OUT    <= 1'b0;
            RX_BAUD_TICK_OUT <= 1'b0;
            TX_BAUD_TICK_OUT <= 1'b0;
        end
        else
        begin
            TIMER_IRQ_OUT <= TIMER_INT_EN_IN
                             && (control_reg[atc_pkg::BIT_OVF]
                                 || (control_reg[atc_pkg::BIT_EXF] && !updown_count_enable_reg));
            RX_BAUD_TICK_OUT <= timer_mode
                                && (control_reg[atc_pkg::BIT_RCLK] ? overflow
                                                                   : TIMER1_OVF_IN);
            TX_BAUD_TICK_OUT <= timer_mode
                                && (control_reg[atc_pkg::BIT_TX_BAUD_SOURCE_SEL] ? overflow
                                                                   : TIMER1_OVF_IN);
        end
    end
endmodule : atc_timer

/* File: atc_timer_asserts.sv */
`timescale 1ns/1ns
// ----------------------------------------
// port checker for the aux timer
// ----------------------------------------
module atc_timer_asserts
(
    // clock and reset
    input wire logic       CORE_CLK_IN,
    input wire logic       SRST_IN,
    // register access
    input wire logic [7:0] SFR_ADDR_IN,
    input wire logic       SFR_WR_IN,
    input wire logic       SFR_RD_IN,
    input wire logic [7:0] SFR_WDATA_IN,
    input wire logic [7:0] SFR_RDATA_OUT,
    // interrupt and serial port
    input wire logic       TIMER_INT_EN_IN,
    input wire logic       TIMER_IRQ_OUT,
    input wire logic [1:0] SERIAL_MODE_IN,
    input wire logic       TIMER1_OVF_IN,
    input wire logic       RX_BAUD_TICK_OUT,
    input wire logic       TX_BAUD_TICK_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (SRST_IN);
    logic [7:0] ctl_reg; // software-owned control bits
    logic       m13;     // serial mode takes timer baud
    assign m13 = SERIAL_MODE_IN == atc_pkg::SERIAL_MODE_1
                 || SERIAL_MODE_IN == atc_pkg::SERIAL_MODE_3;
    // shadow of control writes; hardware never touches bits 5..0
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (SRST_IN)
            ctl_reg <= 8'h00;
        else if (SFR_WR_IN && SFR_ADDR_IN == atc_pkg::ADDR_CONTROL)
            ctl_reg <= SFR_WDATA_IN;
    end
    unmapped_read_a: assert property (SFR_RD_IN
        && (SFR_ADDR_IN < 8'hc8 || SFR_ADDR_IN > 8'hcd) |=> SFR_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!SFR_RD_IN |=> $stable(SFR_RDATA_OUT))
        else $error("read data moved without read");
    mode_spare_a: assert property (SFR_RD_IN && SFR_ADDR_IN == atc_pkg::ADDR_MODE
        |=> SFR_RDATA_OUT[7:1] == 7'h00) else $error("mode spare bits set");
    irq_gate_a: assert property (!TIMER_INT_EN_IN |=> !TIMER_IRQ_OUT)
        else $error("irq without enable");
    rx_timer1_a: assert property (m13 && !ctl_reg[5] && TIMER1_OVF_IN
        |-> ##1 RX_BAUD_TICK_OUT) else $error("rx tick missing");
    rx_quiet_a: assert property (!ctl_reg[5] && !TIMER1_OVF_IN |=> !RX_BAUD_TICK_OUT)
        else $error("stray rx tick");
    tx_timer1_a: assert property (m13 && !ctl_reg[4] && TIMER1_OVF_IN
        |-> ##1 TX_BAUD_TICK_OUT) else $error("tx tick missing");
    tx_quiet_a: assert property (!ctl_reg[4] && !TIMER1_OVF_IN |=> !TX_BAUD_TICK_OUT)
        else $error("stray tx tick");
    mode_mask_a: assert property (!m13 |=> !RX_BAUD_TICK_OUT && !TX_BAUD_TICK_OUT)
        else $error("tick outside modes 1 and 3");
    stop_quiet_a: assert property (ctl_reg[5] && !ctl_reg[2] [*2] |=> !RX_BAUD_TICK_OUT)
        else $error("stopped timer ticked");
    cover property (RX_BAUD_TICK_OUT && ctl_reg[5]);
    cover property (TX_BAUD_TICK_OUT && !ctl_reg[4]);
    cover property (TIMER_IRQ_OUT);
endmodule : atc_timer_asserts

bind atc_timer atc_timer_asserts chk (.CORE_CLK_IN, .SRST_IN, .SFR_ADDR_IN, .SFR_WR_IN,
    .SFR_RD_IN, .SFR_WDATA_IN, .SFR_RDATA_OUT, .TIMER_INT_EN_IN, .TIMER_IRQ_OUT,
    .SERIAL_MODE_IN, .TIMER1_OVF_IN, .RX_BAUD_TICK_OUT, .TX_BAUD_TICK_OUT);

/* File: atc_pins_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// pins and timer 1 seen from outside
// ----------------------------------------
module atc_pins_model
(
    // clock and commands
    input  wire logic clk_in,
    input  wire logic count_fire_in,
    input  wire logic trig_fire_in,
    input  wire logic t1_run_in,
    // pins, pulled high when idle; timer 1 overflow, low when idle
    output logic      count_pin_out,
    output logic      trig_pin_out,
    output logic      t1_ovf_out
);
    logic [3:0] cnt_low_reg = 4'h0; // count pin low time left
    logic [3:0] trg_low_reg = 4'h0; // trigger pin low time left
    logic [4:0] t1_reg      = 5'h0; // timer 1 period divider
    assign count_pin_out = cnt_low_reg == 4'h0;
    assign trig_pin_out  = trg_low_reg == 4'h0;
    // each command pulls a pin low for eight cycles
    always @(posedge clk_in)
    begin
        cnt_low_reg <= count_fire_in ? 4'h8 : cnt_low_reg - 4'(cnt_low_reg != 4'h0);
        trg_low_reg <= trig_fire_in ? 4'h8 : trg_low_reg - 4'(trg_low_reg != 4'h0);
        t1_reg      <= (t1_reg == 5'h13) ? 5'h0 : t1_reg + 5'h1;
        t1_ovf_out  <= t1_run_in && t1_reg == 5'h0;
    end
endmodule : atc_pins_model

/* File: atc_timer_test.sv */
`timescale 1ns/1ns
module atc_timer_test;
    logic       clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, irq_en = 1'b0;
    logic       cf = 1'b0, tf = 1'b0, t1_run = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, r;
    logic [1:0] mode = 2'h0;
    wire  [7:0] rdata;
    wire        cpin, tpin, t1, irq, rxt, txt;
    int         miscompares = 0, checked = 0, rx_n = 0, tx_n = 0, n0, n1;
    atc_pins_model pm (.clk_in(clk), .count_fire_in(cf), .trig_fire_in(tf), .t1_run_in(t1_run),
        .count_pin_out(cpin), .trig_pin_out(tpin), .t1_ovf_out(t1));
    atc_timer dut (.CORE_CLK_IN(clk), .SRST_IN(srst), .SFR_ADDR_IN(addr), .SFR_WR_IN(wr),
        .SFR_RD_IN(rd), .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata), .COUNT_PIN_IN(cpin),
        .EXT_TRIGGER_PIN_IN(tpin), .TIMER_INT_EN_IN(irq_en), .TIMER_IRQ_OUT(irq),
        .SERIAL_MODE_IN(mode), .TIMER1_OVF_IN(t1), .RX_BAUD_TICK_OUT(rxt), .TX_BAUD_TICK_OUT(txt));
    // ----------------------------------------
    // clock, tick counters, watchdog
    // ----------------------------------------
    initial forever #50 clk = ~clk;
    always @(posedge clk) rx_n += rxt;
    always @(posedge clk) tx_n += txt;
    initial
    begin
        #2000000;
        miscompares++;
        end_sim();
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] ticks_for(input logic [1:0] m, input logic [7:0] n);
        return (m == 2'h1 || m == 2'h3) ? n : 8'h00;
    endfunction : ticks_for
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr8
    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, e);
    endtask : rd8
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr8(a, d[7:0]);
        wr8(a + 8'h1, d[15:8]);
    endtask : wr16
    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd8(a, e[7:0]);
        rd8(a + 8'h1, e[15:8]);
    endtask : rd16
    // one falling edge on the count pin or the trigger pin
    task automatic pulse(input logic trig);
        @(posedge clk);
        cf <= !trig;
        tf <= trig;
        @(posedge clk);
        cf <= 1'b0;
        tf <= 1'b0;
        repeat (16) @(posedge clk);
    endtask : pulse
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        #1 check({7'h00, irq}, {7'h00, e});
    endtask : irq_is
    task automatic window(input logic [7:0] erx, input logic [7:0] etx);
        @(negedge clk);
        n0 = rx_n;
        n1 = tx_n;
        repeat (200) @(negedge clk);
        check(8'(rx_n - n0), erx);
        check(8'(tx_n - n1), etx);
    endtask : window
    task automatic end_sim();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(50));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (int a = 'hc8; a <= 'hcd; a++) rd8(8'(a), 8'h00);
        rd8(8'($urandom_range(199, 192)), 8'h00);
        for (int a = 'hca; a <= 'hcd; a++)
        begin
            r = 8'($urandom);
            wr8(8'(a), r);
            rd8(8'(a), r);
        end
        r = 8'($urandom) & 8'h0b;
        wr8(8'hc8, r);
        rd8(8'hc8, r);
        $display("registers done");
        wr16(8'hca, 16'h1234);
        wr16(8'hcc, 16'hfffe);
        wr8(8'hc8, 8'h06);
        pulse(1'b0);
        pulse(1'b0);
        rd8(8'hc8, 8'h86);
        rd16(8'hcc, 16'h1234);
        wr8(8'hc8, 8'h82);
        pulse(1'b0);
        rd16(8'hcc, 16'h1234);
        rd8(8'hc8, 8'h82);
        wr16(8'hcc, 16'h0100);
        wr8(8'hc8, 8'h04);
        repeat (58) @(posedge clk);
        wr8(8'hc8, 8'h00);
        rd16(8'hcc, 16'h0105);
        rd8(8'hc8, 8'h00);
        // capture mode: overflow wraps to zero, no reload
        wr16(8'hcc, 16'hffff);
        wr8(8'hc8, 8'h07);
        pulse(1'b0);
        rd16(8'hcc, 16'h0000);
        rd8(8'hc8, 8'h87);
        $display("overflow done");
        wr16(8'hcc, 16'habcd);
        wr8(8'hc8, 8'h0b);
        pulse(1'b1);
        rd16(8'hca, 16'habcd);
        rd8(8'hc8, 8'h4b);
        @(posedge clk);
        irq_en <= 1'b1;
        irq_is(1'b1);
        wr8(8'hc9, 8'h01);
        irq_is(1'b0);
        // up/down enable leaves the overflow flag request alone
        wr8(8'hc8, 8'hcb);
        irq_is(1'b1);
        wr8(8'hc9, 8'h00);
        wr8(8'hc8, 8'h03);
        irq_is(1'b0);
        wr16(8'hcc, 16'h0042);
        pulse(1'b1);
        rd16(8'hca, 16'habcd);
        rd8(8'hc8, 8'h03);
        wr16(8'hca, 16'h5678);
        wr8(8'hc8, 8'h08);
        pulse(1'b1);
        rd16(8'hcc, 16'h5678);
        rd8(8'hc8, 8'h48);
        @(posedge clk);
        irq_en <= 1'b0;
        $display("trigger done");
        mode <= 2'h1;
        wr16(8'hca, 16'h1111);
        wr16(8'hcc, 16'hffff);
        wr8(8'hc8, 8'h3f);
        n0 = rx_n;
        n1 = tx_n;
        pulse(1'b0);
        check(8'(rx_n - n0), 8'h01);
        check(8'(tx_n - n1), 8'h01);
        rd16(8'hcc, 16'h1111);
        // count differs from pair so a stray capture shows
        wr16(8'hcc, 16'h2222);
        pulse(1'b1);
        rd16(8'hca, 16'h1111);
        rd8(8'hc8, 8'h3f);
        t1_run <= 1'b1;
        wr8(8'hc8, 8'h30);
        window(8'h00, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            mode <= 2'(m);
            wr8(8'hc8, 8'h00);
            window(ticks_for(2'(m), 8'h0a), ticks_for(2'(m), 8'h0a));
        end
        @(posedge clk);
        mode <= 2'h1;
        wr8(8'hc8, 8'h10);
        window(8'h0a, 8'h00);
        $display("baud done");
        end_sim();
    end
endmodule : atc_timer_test
